// ===== rtl/psi_pkg.sv
// Shared constants and types of the power stage start interlock
package psi_pkg;

   // Clock and timing figures
   localparam longint unsigned CLK_HZ        = 64'd25000000;
   localparam longint unsigned PULSE_MAX_MS  = 64'd2000;
   localparam longint unsigned AUTO_DELAY_MS = 64'd100;
   localparam longint unsigned MS_PER_S      = 64'd1000;
   // Longest pulse rounds down, least delay rounds up
   localparam longint unsigned PULSE_MAX_CYC  = (PULSE_MAX_MS * CLK_HZ) / MS_PER_S;
   localparam longint unsigned AUTO_DELAY_CYC = (AUTO_DELAY_MS * CLK_HZ + MS_PER_S - 64'd1) / MS_PER_S;
   localparam int              CNT_W          = 26;

   // Register byte offsets
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;

   // Control register fields
   localparam int CTRL_MODE_BIT   = 0;
   localparam int CTRL_ASSIGN_BIT = 1;
   localparam int CTRL_ACK_BIT    = 2;

   // Status register field positions
   localparam int STAT_STATE_LSB   = 0;
   localparam int STAT_RELEASE_BIT = 4;
   localparam int STAT_ERR_LSB     = 5;
   localparam int STAT_IN_LSB      = 8;

   // Start mode type and start input assignment
   typedef enum logic {
      PSI_MODE_PULSE = 1'b0,
      PSI_MODE_AUTO  = 1'b1
   } psi_mode_type;

   typedef enum logic {
      PSI_IN_NONE  = 1'b0,
      PSI_IN_START = 1'b1
   } psi_assign_type;

   localparam psi_mode_type   MODE_RESET   = PSI_MODE_PULSE;
   localparam psi_assign_type ASSIGN_RESET = PSI_IN_NONE;

   // Operating states, one-hot
   typedef enum logic [3:0] {
      PSI_SWITCH_ON_DISABLED = 4'h1,
      PSI_READY_TO_SWITCH_ON = 4'h2,
      PSI_OPERATION_ENABLED  = 4'h4,
      PSI_FAULT              = 4'h8
   } psi_state_type;

   // Sticky error flags
   typedef struct packed {
      logic missing_level;
      logic stuck_at_entry;
      logic pulse_too_long;
   } psi_err_type;

   // Synchronised safety inputs
   typedef struct packed {
      logic start;
      logic sls;
      logic ss1;
   } psi_in_type;

endpackage : psi_pkg

// ===== rtl/psi_input_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
module psi_input_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // Shift chain; stage1 feeds only stage2
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Take a change only once two later stages agree, per bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_out <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
               sync_out[i] <= stage3[i];
            end
         end
      end
   end

endmodule : psi_input_sync

// ===== rtl/psi_interlock.sv
// Start signal interlock for power stage enabling, with APB registers
// How it works
// - Lock power stage at switch-on, after error clear, after speed-limit torque off and stop 1.
// - Leave switch-on-disabled only when both stop and speed-limit requests are high.
// - Pulse mode with start input: wait for a pulse, then enable operation.
// - Pulse mode with start input: start held active beyond 2 s raises an error.
// - Pulse mode with start input: start already active on entering ready raises an error.
// - Level mode with input: active on entry gives operation enabled after 0.1 s.
// - Level mode with input: inactive on entry raises an error.
// - Level mode without input: operation enabled automatically after 0.1 s.
// - Start mode setting offers pulse or automatic level start.
// - Start input setting offers not assigned or the start safety input.
`timescale 1ns/100ps
module psi_interlock #(
   parameter int unsigned PULSE_MAX_CYC  = int'(psi_pkg::PULSE_MAX_CYC),
   parameter int unsigned AUTO_DELAY_CYC = int'(psi_pkg::AUTO_DELAY_CYC)
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ss1_request_in,
   input  wire logic        sls_request_in,
   input  wire logic        start_safety_input,
   input  wire logic        sls_sto_event,
   input  wire logic        ss1_done_event,
   output logic             power_enable_release
);

   localparam int CW = psi_pkg::CNT_W;
   localparam logic [CW-1:0] PULSE_MAX  = CW'(PULSE_MAX_CYC);
   localparam logic [CW-1:0] AUTO_LAST  = CW'(AUTO_DELAY_CYC - 1);
   localparam logic [CW-1:0] CNT_ONE    = {{(CW-1){1'b0}}, 1'b1};

   psi_pkg::psi_state_type  state;
   psi_pkg::psi_state_type  next_state;
   psi_pkg::psi_mode_type   start_mode;
   psi_pkg::psi_assign_type start_assign;
   psi_pkg::psi_err_type    err;
   psi_pkg::psi_err_type    next_err_set;
   psi_pkg::psi_in_type     sin;
   logic                    entry;
   logic                    start_prev;
   logic [CW-1:0]           cnt;
   logic                    bus_write;
   logic                    bus_read;
   logic                    ack_write;
   logic                    addr_ok;
   logic                    requests_removed;
   logic                    lock_event;
   logic                    pulse_mode;
   logic                    input_assigned;
   logic [31:0]             status_word;

   // Pin inputs pass the three-stage filter
   psi_input_sync #(
      .WIDTH (3)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .pin_in   ({start_safety_input, sls_request_in, ss1_request_in}),
      .sync_out (sin)
   );

   // Bus strobes; writes act only in the access phase with pready high
   assign bus_write = psel && penable && pready && pwrite;
   assign bus_read  = psel && !penable && !pwrite;
   assign addr_ok   = (paddr == psi_pkg::CTRL_ADDR) || (paddr == psi_pkg::STATUS_ADDR);
   assign ack_write = bus_write && (paddr == psi_pkg::CTRL_ADDR) && pwdata[psi_pkg::CTRL_ACK_BIT];

   assign requests_removed = sin.ss1 && sin.sls;
   assign lock_event       = sls_sto_event || ss1_done_event;
   assign pulse_mode       = (start_mode == psi_pkg::PSI_MODE_PULSE);
   assign input_assigned   = (start_assign == psi_pkg::PSI_IN_START);

   // Configuration register; safe to change at run time, used by the state logic at once, also in ready-to-switch-on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_mode   <= psi_pkg::MODE_RESET;
         start_assign <= psi_pkg::ASSIGN_RESET;
      end else if (bus_write && addr_ok && (paddr == psi_pkg::CTRL_ADDR)) begin
         start_mode   <= psi_pkg::psi_mode_type'(pwdata[psi_pkg::CTRL_MODE_BIT]);
         start_assign <= psi_pkg::psi_assign_type'(pwdata[psi_pkg::CTRL_ASSIGN_BIT]);
      end
   end

   // Error detection in ready-to-switch-on
   always_comb begin
      next_err_set = '0;
      if (state == psi_pkg::PSI_READY_TO_SWITCH_ON && input_assigned) begin
         if (pulse_mode) begin
            next_err_set.stuck_at_entry = entry && sin.start;
            next_err_set.pulse_too_long = !entry && sin.start && (cnt == PULSE_MAX);
         end else begin
            // A start that drops during the delay counts as missing too
            next_err_set.missing_level = !sin.start;
         end
      end
   end

   // State transitions; errors beat locks, locks beat starts
   always_comb begin
      next_state = state;
      case (state)
         psi_pkg::PSI_SWITCH_ON_DISABLED: begin
            if (requests_removed && !lock_event) begin
               next_state = psi_pkg::PSI_READY_TO_SWITCH_ON;
            end
         end
         psi_pkg::PSI_READY_TO_SWITCH_ON: begin
            if (next_err_set != '0) begin
               next_state = psi_pkg::PSI_FAULT;
            end else if (!requests_removed || lock_event) begin
               next_state = psi_pkg::PSI_SWITCH_ON_DISABLED;
            end else if (pulse_mode) begin
               // Falling edge of a pulse no longer than the timeout
               if (input_assigned && !entry && start_prev && !sin.start && cnt <= PULSE_MAX) begin
                  next_state = psi_pkg::PSI_OPERATION_ENABLED;
               end
            end else if (cnt == AUTO_LAST) begin
               next_state = psi_pkg::PSI_OPERATION_ENABLED;
            end
         end
         psi_pkg::PSI_OPERATION_ENABLED: begin
            if (!requests_removed || lock_event) begin
               next_state = psi_pkg::PSI_SWITCH_ON_DISABLED;
            end
         end
         psi_pkg::PSI_FAULT: begin
            // Leave only on an acknowledge write; no error is detected while in fault
            if (ack_write) begin
               next_state = psi_pkg::PSI_SWITCH_ON_DISABLED;
            end
         end
         default: begin
            next_state = psi_pkg::PSI_SWITCH_ON_DISABLED;
         end
      endcase
   end

   // State register; reset is switch-on, so start locked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= psi_pkg::PSI_SWITCH_ON_DISABLED;
      end else begin
         state <= next_state;
      end
   end

   // Entry marker for ready-to-switch-on checks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         entry <= 1'b0;
      end else begin
         entry <= (next_state == psi_pkg::PSI_READY_TO_SWITCH_ON) && (state != psi_pkg::PSI_READY_TO_SWITCH_ON);
      end
   end

   // Shared counter: pulse length in pulse mode, start delay otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt        <= '0;
         start_prev <= 1'b0;
      end else begin
         start_prev <= sin.start;
         if (state != psi_pkg::PSI_READY_TO_SWITCH_ON || entry && pulse_mode) begin
            cnt <= '0;
         end else if (pulse_mode) begin
            // Saturates so a tied input cannot wrap round into a valid pulse
            if (!sin.start) begin
               cnt <= '0;
            end else if (cnt != PULSE_MAX) begin
               cnt <= cnt + CNT_ONE;
            end
         end else if (cnt != AUTO_LAST) begin
            cnt <= cnt + CNT_ONE;
         end
      end
   end

   // Sticky errors; a new error wins over acknowledge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err <= '0;
      end else begin
         err <= (ack_write ? '0 : err) | next_err_set;
      end
   end

   // Release registered from the next state, so it changes in the same cycle as the state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_enable_release <= 1'b0;
      end else begin
         power_enable_release <= (next_state == psi_pkg::PSI_OPERATION_ENABLED);
      end
   end

   // Status word assembly
   always_comb begin
      status_word = '0;
      status_word[psi_pkg::STAT_STATE_LSB +: 4] = state;
      status_word[psi_pkg::STAT_RELEASE_BIT]    = power_enable_release;
      status_word[psi_pkg::STAT_ERR_LSB +: 3]   = err;
      status_word[psi_pkg::STAT_IN_LSB +: 3]    = sin;
   end

   // APB slave: answer in the first access cycle, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (bus_read && paddr == psi_pkg::CTRL_ADDR) begin
            prdata <= {30'h0, start_assign, start_mode};
         end else if (bus_read && paddr == psi_pkg::STATUS_ADDR) begin
            prdata <= status_word;
         end else begin
            prdata <= '0;
         end
      end
   end

   // Checks
   property p_locked_no_release;
      @(posedge pclk) disable iff (!presetn)
      (state == psi_pkg::PSI_SWITCH_ON_DISABLED) || (state == psi_pkg::PSI_FAULT) |-> !power_enable_release;
   endproperty
   a_locked_no_release: assert property (p_locked_no_release) else $error("release while locked");

   property p_lock_event;
      @(posedge pclk) disable iff (!presetn)
      lock_event |=> !power_enable_release && state != psi_pkg::PSI_OPERATION_ENABLED;
   endproperty
   a_lock_event: assert property (p_lock_event) else $error("lock event did not lock");

   property p_wait_requests;
      @(posedge pclk) disable iff (!presetn)
      (state == psi_pkg::PSI_SWITCH_ON_DISABLED) && !requests_removed |=> state == psi_pkg::PSI_SWITCH_ON_DISABLED;
   endproperty
   a_wait_requests: assert property (p_wait_requests) else $error("left disabled with request active");

   property p_pulse_start;
      @(posedge pclk) disable iff (!presetn)
      $rose(power_enable_release) && pulse_mode |-> $past(start_prev, 1) && !$past(sin.start, 1) && input_assigned;
   endproperty
   a_pulse_start: assert property (p_pulse_start) else $error("pulse start without falling edge");

   property p_pulse_long;
      @(posedge pclk) disable iff (!presetn)
      state == psi_pkg::PSI_READY_TO_SWITCH_ON && pulse_mode && input_assigned && !entry && sin.start
      && cnt == PULSE_MAX |=> err.pulse_too_long && state == psi_pkg::PSI_FAULT;
   endproperty
   a_pulse_long: assert property (p_pulse_long) else $error("long pulse not flagged");

   property p_stuck;
      @(posedge pclk) disable iff (!presetn)
      entry && state == psi_pkg::PSI_READY_TO_SWITCH_ON && pulse_mode && input_assigned && sin.start
      |=> err.stuck_at_entry ##1 !power_enable_release;
   endproperty
   a_stuck: assert property (p_stuck) else $error("start active on entry not flagged");

   property p_missing;
      @(posedge pclk) disable iff (!presetn)
      entry && state == psi_pkg::PSI_READY_TO_SWITCH_ON && !pulse_mode && input_assigned && !sin.start
      |=> err.missing_level && state == psi_pkg::PSI_FAULT;
   endproperty
   a_missing: assert property (p_missing) else $error("missing level not flagged");

   property p_auto_delay;
      @(posedge pclk) disable iff (!presetn)
      state == psi_pkg::PSI_READY_TO_SWITCH_ON && !pulse_mode && cnt == AUTO_LAST && requests_removed
      && !lock_event && (sin.start || !input_assigned)
      |=> power_enable_release && state == psi_pkg::PSI_OPERATION_ENABLED;
   endproperty
   a_auto_delay: assert property (p_auto_delay) else $error("auto start not taken");

   property p_early_release;
      @(posedge pclk) disable iff (!presetn)
      state == psi_pkg::PSI_READY_TO_SWITCH_ON && !pulse_mode && cnt != AUTO_LAST |=> !power_enable_release;
   endproperty
   a_early_release: assert property (p_early_release) else $error("auto start too early");

   property p_ack_set_wins;
      @(posedge pclk) disable iff (!presetn)
      ack_write && next_err_set != '0 |=> err != '0;
   endproperty
   a_ack_set_wins: assert property (p_ack_set_wins) else $error("error lost on acknowledge");

   // Transition checks; each names the step that must or must not follow
   property p_enter_ready;
      @(posedge pclk) disable iff (!presetn)
      state == psi_pkg::PSI_SWITCH_ON_DISABLED && requests_removed && !lock_event
      |=> state == psi_pkg::PSI_READY_TO_SWITCH_ON;
   endproperty
   a_enter_ready: assert property (p_enter_ready) else $error("requests removed but not ready");

   property p_no_input_wait;
      @(posedge pclk) disable iff (!presetn)
      state == psi_pkg::PSI_READY_TO_SWITCH_ON && pulse_mode && !input_assigned |=> !power_enable_release;
   endproperty
   a_no_input_wait: assert property (p_no_input_wait) else $error("pulse start without input");

   property p_pulse_held;
      @(posedge pclk) disable iff (!presetn)
      state == psi_pkg::PSI_READY_TO_SWITCH_ON && pulse_mode && sin.start |=> !power_enable_release;
   endproperty
   a_pulse_held: assert property (p_pulse_held) else $error("start while pulse still active");

   property p_pulse_done;
      @(posedge pclk) disable iff (!presetn)
      state == psi_pkg::PSI_READY_TO_SWITCH_ON && pulse_mode && input_assigned && !entry && start_prev
      && !sin.start && requests_removed && !lock_event |=> power_enable_release;
   endproperty
   a_pulse_done: assert property (p_pulse_done) else $error("pulse end did not start");

   property p_fault_hold;
      @(posedge pclk) disable iff (!presetn)
      state == psi_pkg::PSI_FAULT && !ack_write |=> state == psi_pkg::PSI_FAULT && !power_enable_release;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault left without acknowledge");

   property p_fault_ack;
      @(posedge pclk) disable iff (!presetn)
      state == psi_pkg::PSI_FAULT && ack_write |=> state == psi_pkg::PSI_SWITCH_ON_DISABLED;
   endproperty
   a_fault_ack: assert property (p_fault_ack) else $error("acknowledge did not lock");

   property p_request_drop;
      @(posedge pclk) disable iff (!presetn)
      state == psi_pkg::PSI_OPERATION_ENABLED && !requests_removed |=> state == psi_pkg::PSI_SWITCH_ON_DISABLED;
   endproperty
   a_request_drop: assert property (p_request_drop) else $error("request did not stop operation");

   property p_level_entry;
      @(posedge pclk) disable iff (!presetn)
      entry && state == psi_pkg::PSI_READY_TO_SWITCH_ON && !pulse_mode && input_assigned && sin.start
      && requests_removed && !lock_event |=> state != psi_pkg::PSI_FAULT;
   endproperty
   a_level_entry: assert property (p_level_entry) else $error("level present but fault raised");

endmodule : psi_interlock

// ===== test/psi_drive_model.sv
// Drive power stage control and start button model
`timescale 1ns/100ps
module psi_drive_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic release_in,
   output logic      power_on,
   output logic      start_button
);
   initial start_button = 1'b0;

   // Power stage follows release one cycle late, never ahead of it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_on <= 1'b0;
      end else begin
         power_on <= release_in;
      end
   end

   // Button press of a given length, changed right after an edge
   task automatic press(input int len);
      start_button <= 1'b1;
      repeat (len) @(posedge pclk);
      start_button <= 1'b0;
   endtask : press

   // Held contact, as a welded button or an external device
   task automatic level(input logic v);
      start_button <= v;
   endtask : level
endmodule : psi_drive_model

// ===== test/power_stage_start_interlock_bench.sv
// Self-checking bench of the power stage start interlock
`timescale 1ns/100ps
module power_stage_start_interlock_bench;
   localparam int unsigned PMAX = 20;
   localparam int unsigned ADLY = 5;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ss1     = 1'b0;
   logic        sls     = 1'b0;
   logic        sto_ev  = 1'b0;
   logic        ss1_ev  = 1'b0;
   logic        start_btn;
   logic        power_enable_release;
   logic        power_on;
   logic [31:0] rd;
   logic        err;
   int          miscompares  = 0;
   int          total_checks = 0;
   int          n;

   // 25 MHz clock
   always #20 pclk = ~pclk;

   psi_interlock #(.PULSE_MAX_CYC(PMAX), .AUTO_DELAY_CYC(ADLY)) dut (
      .pclk                 (pclk),
      .presetn              (presetn),
      .psel                 (psel),
      .penable              (penable),
      .pwrite               (pwrite),
      .paddr                (paddr),
      .pwdata               (pwdata),
      .prdata               (prdata),
      .pready               (pready),
      .pslverr              (pslverr),
      .ss1_request_in       (ss1),
      .sls_request_in       (sls),
      .start_safety_input   (start_btn),
      .sls_sto_event        (sto_ev),
      .ss1_done_event       (ss1_ev),
      .power_enable_release (power_enable_release)
   );

   psi_drive_model drv (
      .pclk         (pclk),
      .presetn      (presetn),
      .release_in   (power_enable_release),
      .power_on     (power_on),
      .start_button (start_btn)
   );

   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic timeout;
      miscompares++;
      $display("wrong value at %0t: wait ran out", $time);
      report_and_stop();
   endtask : timeout

   // One APB transfer, entered and left just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) timeout();
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Status low byte: state, release and error flags
   task automatic stat(input logic [7:0] exp);
      apb(1'b0, psi_pkg::STATUS_ADDR, 32'h0);
      check({24'h0, rd[7:0]}, {24'h0, exp});
   endtask : stat

   task automatic wait_rel(input logic v, input int b);
      for (n = 0; n < b; n++) begin
         if (power_enable_release === v) break;
         @(posedge pclk);
      end
      if (n == b) timeout();
   endtask : wait_rel

   // Both requests set alike, then given time to pass the pin filter
   task automatic req(input logic v);
      ss1 <= v;
      sls <= v;
      repeat (8) @(posedge pclk);
   endtask : req

   task automatic pulse_event(input int k);
      if (k == 0) ss1_ev <= 1'b1;
      else sto_ev <= 1'b1;
      @(posedge pclk);
      ss1_ev <= 1'b0;
      sto_ev <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : pulse_event

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, psi_pkg::CTRL_ADDR, 32'h0);
      check(rd, 32'h0);
      stat(8'h01);
      apb(1'b0, 8'h08, 32'h0);
      check(32'(err), 32'h1);
      check(rd, 32'h0);
      // Automatic start without input; one request alone must not start
      apb(1'b1, psi_pkg::CTRL_ADDR, 32'h1);
      apb(1'b0, psi_pkg::CTRL_ADDR, 32'h0);
      check(rd, 32'h1);
      ss1 <= 1'b1;
      repeat (10) @(posedge pclk);
      stat(8'h01);
      sls <= 1'b1;
      wait_rel(1'b1, 40);
      check(32'(n >= ADLY + 3 && n <= ADLY + 6), 32'h1);
      stat(8'h14);
      check(32'(power_on), 32'h1);
      // Each lock event drops the release, automatic start follows
      for (int k = 0; k < 2; k++) begin
         pulse_event(k);
         check(32'(power_enable_release), 32'h0);
         wait_rel(1'b1, 40);
      end
      // Pulse mode with no input waits in ready despite a press
      apb(1'b1, psi_pkg::CTRL_ADDR, 32'h0);
      req(1'b0);
      req(1'b1);
      drv.press(4);
      repeat (8) @(posedge pclk);
      stat(8'h02);
      // Assigned input: start counts at the end of the pulse
      apb(1'b1, psi_pkg::CTRL_ADDR, 32'h2);
      apb(1'b0, psi_pkg::CTRL_ADDR, 32'h0);
      check(rd, 32'h2);
      drv.press(4);
      check(32'(power_enable_release), 32'h0);
      wait_rel(1'b1, 40);
      stat(8'h14);
      // Overlong pulse, then acknowledge
      req(1'b0);
      req(1'b1);
      drv.press(PMAX + 10);
      repeat (6) @(posedge pclk);
      stat(8'h28);
      apb(1'b1, psi_pkg::CTRL_ADDR, 32'h6);
      stat(8'h02);
      // Contact already closed on entry to ready
      drv.level(1'b1);
      req(1'b0);
      req(1'b1);
      stat(8'h48);
      drv.level(1'b0);
      repeat (6) @(posedge pclk);
      apb(1'b1, psi_pkg::CTRL_ADDR, 32'h6);
      stat(8'h02);
      // Level start with input: missing level on entry, then a proper start
      req(1'b0);
      apb(1'b1, psi_pkg::CTRL_ADDR, 32'h3);
      req(1'b1);
      stat(8'h88);
      drv.level(1'b1);
      repeat (6) @(posedge pclk);
      apb(1'b1, psi_pkg::CTRL_ADDR, 32'h7);
      wait_rel(1'b1, 40);
      stat(8'h14);
      apb(1'b0, psi_pkg::CTRL_ADDR, 32'h0);
      check(rd, 32'h3);
      // Reset in mid-run: locked again, settings back to pulse without input
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check(32'(power_enable_release), 32'h0);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, psi_pkg::CTRL_ADDR, 32'h0);
      check(rd, 32'h0);
      repeat (8) @(posedge pclk);
      stat(8'h02);
      report_and_stop();
   end
endmodule : power_stage_start_interlock_bench
